// ---- core/nvmsa_map.vh ----
// register map, field positions, reset values and timing counts of the nvm self-access block
// Operation
// - config select redirects accesses to id/config region
// - config region is address bit 15 set
// - user ids rw; device id, config words read-only
// - bad config read clears both data registers
// - data word 14 bits, high bits 7:6 zero
// - address 15 bits, high register bit 7 reads one
// - bit 7 selects flash (1) or eeprom (0); config select forces flash
// - latch-only bit: load latches, else program all
// - eeprom ignores latch-only bit
// - erase bit erases, hardware clears after erase
// - eeprom ignores erase bit, erases then writes
// - error flag set on any write start attempt
// - program enable low blocks all program/erase
// - write start set-only, hardware clears when done
// - read start set-only, one-shot, hardware clears
// - two setup cycles follow write start
// - no stall for latch-only writes
`ifndef NVMSA_MAP_VH
`define NVMSA_MAP_VH

// register offsets
`define NVMSA_OFF_DATA_LO   4'h0
`define NVMSA_OFF_DATA_HI   4'h1
`define NVMSA_OFF_ADDR_LO   4'h2
`define NVMSA_OFF_ADDR_HI   4'h3
`define NVMSA_OFF_CTRL      4'h4
`define NVMSA_OFF_KEY       4'h5
`define NVMSA_OFF_IRQ_STAT  4'h6
`define NVMSA_OFF_IRQ_MASK  4'h7

// control register bit positions
`define NVMSA_B_PGD   7
`define NVMSA_B_CONFIG_SPACE_SELECT  6
`define NVMSA_B_LATCH_LOAD_ONLY  5
`define NVMSA_B_FREE  4
`define NVMSA_B_WERR  3
`define NVMSA_B_PROGRAM_ENABLE  2
`define NVMSA_B_WR    1
`define NVMSA_B_RD    0

// interrupt status bit positions
`define NVMSA_I_DONE  0
`define NVMSA_I_REF   1

// reset values
`define NVMSA_RST_DATA  14'h0000
`define NVMSA_RST_ADDR  15'h0000

// unlock keys and key sequence states
`define NVMSA_KEY_1     8'h55
`define NVMSA_KEY_2     8'haa
`define NVMSA_KS_IDLE   2'h0
`define NVMSA_KS_HALF   2'h1
`define NVMSA_KS_OPEN   2'h2

// storage commands
`define NVMSA_CMD_IDLE  3'h0
`define NVMSA_CMD_READ  3'h1
`define NVMSA_CMD_LATCH 3'h2
`define NVMSA_CMD_ERASE 3'h3
`define NVMSA_CMD_PROG  3'h4
`define NVMSA_CMD_EEWR  3'h5

// configuration space addresses
`define NVMSA_CFG_UID_LAST  15'h0003
`define NVMSA_CFG_DEVID     15'h0006
`define NVMSA_CFG_WORD_1ST  15'h0007
`define NVMSA_CFG_WORD_LAST 15'h0008

// timing
`define NVMSA_CLK_MHZ       125
`define NVMSA_PROG_TIME_US  2000
`define NVMSA_OP_CYC        (`NVMSA_PROG_TIME_US * `NVMSA_CLK_MHZ)
`define NVMSA_SETUP_CYC     2

`endif

// ---- core/nvmsa_op_timer.v ----
// self-timed sequencer: setup delay then optional timed storage phase
`timescale 1ns/1ps
module nvmsa_op_timer #(
	parameter CW        = 24,
	parameter SETUP_CYC = 2,
	parameter OP_CYC    = 250000
) (
	// clock and synchronised reset
	input  wire clk_i,
	input  wire rst_n_i,
	// request
	input  wire start_i,
	input  wire timed_i,
	// progress
	output reg  active_o,
	output reg  done_o
);
	localparam [1:0]    S_IDLE  = 2'h0;
	localparam [1:0]    S_SETUP = 2'h1;
	localparam [1:0]    S_RUN   = 2'h2;
	localparam integer  SET_M1  = SETUP_CYC - 1;
	localparam integer  OP_M1   = OP_CYC - 1;
	localparam [CW-1:0] SET_LD  = SET_M1[CW-1:0]; // loads cut to the counter width
	localparam [CW-1:0] OP_LD   = OP_M1[CW-1:0];

	reg [1:0]    state;
	reg [CW-1:0] cnt;
	reg          timed;

	// setup phase always runs; timed phase only for real program/erase
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state    <= S_IDLE;
			cnt      <= {CW{1'b0}};
			timed    <= 1'b0;
			active_o <= 1'b0;
			done_o   <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (state)
			S_IDLE: begin
				if (start_i) begin
					state <= S_SETUP;
					cnt   <= SET_LD;
					timed <= timed_i;
				end
			end
			S_SETUP: begin
				if (cnt == {CW{1'b0}}) begin
					if (timed) begin
						state    <= S_RUN;
						cnt      <= OP_LD;
						active_o <= 1'b1;
					end else begin
						state  <= S_IDLE;
						done_o <= 1'b1;
					end
				end else begin
					cnt <= cnt - 1'b1;
				end
			end
			S_RUN: begin
				if (cnt == {CW{1'b0}}) begin
					state    <= S_IDLE;
					active_o <= 1'b0;
					done_o   <= 1'b1;
				end else begin
					cnt <= cnt - 1'b1;
				end
			end
			default: begin
				state    <= S_IDLE;
				active_o <= 1'b0;
			end
			endcase
		end
	end
endmodule

// ---- core/nvmsa_top.v ----
// nvm self-access control: register set, unlock, read and program/erase sequencing
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "nvmsa_map.vh"
module nvmsa_top #(
	parameter OP_CYCLES = `NVMSA_OP_CYC,
	parameter CW        = 24
) (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_n_i,
	// register port
	input  wire [3:0]  reg_addr_i,
	input  wire [7:0]  reg_wdata_i,
	input  wire        reg_wr_i,
	input  wire        reg_rd_i,
	output reg  [7:0]  reg_rdata_o,
	// storage side
	output reg  [2:0]  mem_cmd_o,
	output reg  [15:0] mem_addr_o,
	output reg  [13:0] mem_wdata_o,
	output reg         mem_flash_o,
	input  wire [13:0] mem_rdata_i,
	// core and interrupt
	output reg         cpu_stall_o,
	output reg         irq_o
);
	// reset release through two flops
	reg rst_s1;
	reg rst_s2;
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_s2 <= rst_s1;
		end
	end
	wire rst_n = rst_s2;

	// register state
	reg [13:0] data_word;
	reg [14:0] addr_word;
	reg        pgd;
	reg        config_space_select;
	reg        latch_load_only;
	reg        free;
	reg        werr;
	reg        program_enable;
	reg        wr_bit;
	reg        rd_bit;
	reg        rd_step;
	reg        rd_bad;
	reg [1:0]  key_state;
	reg [2:0]  op_kind;
	reg        op_stall;
	reg [1:0]  irq_stat;
	reg [1:0]  irq_mask;

	// write decodes
	wire wr_dlo  = reg_wr_i && (reg_addr_i == `NVMSA_OFF_DATA_LO);
	wire wr_dhi  = reg_wr_i && (reg_addr_i == `NVMSA_OFF_DATA_HI);
	wire wr_alo  = reg_wr_i && (reg_addr_i == `NVMSA_OFF_ADDR_LO);
	wire wr_ahi  = reg_wr_i && (reg_addr_i == `NVMSA_OFF_ADDR_HI);
	wire wr_ctrl = reg_wr_i && (reg_addr_i == `NVMSA_OFF_CTRL);
	wire wr_key  = reg_wr_i && (reg_addr_i == `NVMSA_OFF_KEY);
	wire wr_stat = reg_wr_i && (reg_addr_i == `NVMSA_OFF_IRQ_STAT);
	wire wr_mask = reg_wr_i && (reg_addr_i == `NVMSA_OFF_IRQ_MASK);

	// mode bits as carried by the control write itself
	wire w_pgd  = reg_wdata_i[`NVMSA_B_PGD];
	wire w_config_space_select = reg_wdata_i[`NVMSA_B_CONFIG_SPACE_SELECT];
	wire w_latch_load_only = reg_wdata_i[`NVMSA_B_LATCH_LOAD_ONLY];
	wire w_free = reg_wdata_i[`NVMSA_B_FREE];
	wire w_program_enable = reg_wdata_i[`NVMSA_B_PROGRAM_ENABLE];
	wire w_flash = w_pgd || w_config_space_select;

	// configuration space permissions
	wire cfg_wr_ok = (addr_word <= `NVMSA_CFG_UID_LAST);
	wire cfg_rd_ok = cfg_wr_ok || (addr_word == `NVMSA_CFG_DEVID) ||
		((addr_word >= `NVMSA_CFG_WORD_1ST) && (addr_word <= `NVMSA_CFG_WORD_LAST));

	// write start: needs unlock, enable, idle engine and a writable target
	wire wr_try = wr_ctrl && reg_wdata_i[`NVMSA_B_WR];
	wire wr_ok  = wr_try && !wr_bit && (key_state == `NVMSA_KS_OPEN) && w_program_enable &&
		(!w_config_space_select || cfg_wr_ok);
	wire wr_bad = wr_try && !wr_ok;

	// read start: only while no write is pending
	wire rd_go  = wr_ctrl && reg_wdata_i[`NVMSA_B_RD] && !rd_bit && !wr_bit && !wr_ok;
	wire rd_nok = w_config_space_select && !cfg_rd_ok;

	// operation chosen at launch
	reg [2:0] next_kind;
	always @* begin
		if (!w_flash) begin
			next_kind = `NVMSA_CMD_EEWR;
		end else if (w_free) begin
			next_kind = `NVMSA_CMD_ERASE;
		end else if (w_latch_load_only) begin
			next_kind = `NVMSA_CMD_LATCH;
		end else begin
			next_kind = `NVMSA_CMD_PROG;
		end
	end
	wire next_timed = (next_kind != `NVMSA_CMD_LATCH);

	// sequencer
	wire tm_active;
	wire tm_done;
	nvmsa_op_timer #(
		.CW        (CW),
		.SETUP_CYC (`NVMSA_SETUP_CYC),
		.OP_CYC    (OP_CYCLES)
	) u_timer (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n),
		.start_i   (wr_ok),
		.timed_i   (next_timed),
		.active_o  (tm_active),
		.done_o    (tm_done)
	);

	// unlock key sequence, consumed by every write start attempt
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			key_state <= `NVMSA_KS_IDLE;
		end else if (wr_try) begin
			key_state <= `NVMSA_KS_IDLE;
		end else if (wr_key) begin
			if (reg_wdata_i == `NVMSA_KEY_1) begin
				key_state <= `NVMSA_KS_HALF;
			end else if ((key_state == `NVMSA_KS_HALF) && (reg_wdata_i == `NVMSA_KEY_2)) begin
				key_state <= `NVMSA_KS_OPEN;
			end else begin
				key_state <= `NVMSA_KS_IDLE;
			end
		end
	end

	// address register pair
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			addr_word <= `NVMSA_RST_ADDR;
		end else begin
			if (wr_alo) begin
				addr_word[7:0] <= reg_wdata_i;
			end
			if (wr_ahi) begin
				addr_word[14:8] <= reg_wdata_i[6:0];
			end
		end
	end

	// data register pair; read capture overrides software writes
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			data_word <= `NVMSA_RST_DATA;
		end else if (rd_step) begin
			data_word <= rd_bad ? 14'h0000 : mem_rdata_i;
		end else begin
			if (wr_dlo) begin
				data_word[7:0] <= reg_wdata_i;
			end
			if (wr_dhi) begin
				data_word[13:8] <= reg_wdata_i[5:0];
			end
		end
	end

	// control register
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pgd    <= 1'b0;
			config_space_select   <= 1'b0;
			latch_load_only   <= 1'b0;
			free   <= 1'b0;
			werr   <= 1'b0;
			program_enable   <= 1'b0;
			wr_bit <= 1'b0;
		end else begin
			// hardware clears
			if (tm_done) begin
				wr_bit <= 1'b0;
				werr   <= 1'b0;
				if (op_kind == `NVMSA_CMD_ERASE) begin
					free <= 1'b0;
				end
			end
			// software writes
			if (wr_ctrl) begin
				pgd  <= w_pgd;
				config_space_select <= w_config_space_select;
				latch_load_only <= w_latch_load_only;
				free <= w_free;
				program_enable <= w_program_enable;
				werr <= reg_wdata_i[`NVMSA_B_WERR];
			end
			// set-only start and automatic error flag
			if (wr_try) begin
				werr <= 1'b1;
			end
			if (wr_ok) begin
				wr_bit <= 1'b1;
			end
		end
	end

	// read sequence: command cycle, then capture cycle
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rd_bit  <= 1'b0;
			rd_step <= 1'b0;
			rd_bad  <= 1'b0;
		end else if (rd_go) begin
			rd_bit  <= 1'b1;
			rd_step <= 1'b0;
			rd_bad  <= rd_nok;
		end else if (rd_step) begin
			rd_bit  <= 1'b0;
			rd_step <= 1'b0;
		end else if (rd_bit) begin
			rd_step <= 1'b1;
		end
	end

	// operation capture and storage-side outputs
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			op_kind     <= `NVMSA_CMD_IDLE;
			op_stall    <= 1'b0;
			mem_cmd_o   <= `NVMSA_CMD_IDLE;
			mem_addr_o  <= 16'h0000;
			mem_wdata_o <= 14'h0000;
			mem_flash_o <= 1'b0;
			cpu_stall_o <= 1'b0;
		end else begin
			if (wr_ok || rd_go) begin
				mem_addr_o  <= {w_config_space_select, addr_word};
				mem_flash_o <= w_flash;
			end
			if (wr_ok) begin
				op_kind     <= next_kind;
				op_stall    <= w_flash && next_timed;
				mem_wdata_o <= data_word;
			end
			if (rd_go && !rd_nok) begin
				mem_cmd_o <= `NVMSA_CMD_READ;
			end else if (tm_active) begin
				mem_cmd_o <= op_kind;
			end else if (tm_done && (op_kind == `NVMSA_CMD_LATCH)) begin
				mem_cmd_o <= `NVMSA_CMD_LATCH;
			end else begin
				mem_cmd_o <= `NVMSA_CMD_IDLE;
			end
			cpu_stall_o <= tm_active && op_stall;
		end
	end

	// interrupt status, write one to clear, set wins
	wire [1:0] irq_set = {wr_bad, tm_done};
	wire [1:0] irq_clr = wr_stat ? reg_wdata_i[1:0] : 2'h0;
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat <= 2'h0;
			irq_mask <= 2'h0;
			irq_o    <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
			if (wr_mask) begin
				irq_mask <= reg_wdata_i[1:0];
			end
			irq_o <= |(irq_stat & irq_mask);
		end
	end

	// register read-back, data only in the cycle after the strobe
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
			`NVMSA_OFF_DATA_LO:  reg_rdata_o <= data_word[7:0];
			`NVMSA_OFF_DATA_HI:  reg_rdata_o <= {2'h0, data_word[13:8]};
			`NVMSA_OFF_ADDR_LO:  reg_rdata_o <= addr_word[7:0];
			`NVMSA_OFF_ADDR_HI:  reg_rdata_o <= {1'b1, addr_word[14:8]};
			`NVMSA_OFF_CTRL:     reg_rdata_o <= {pgd, config_space_select, latch_load_only, free, werr, program_enable, wr_bit, rd_bit};
			`NVMSA_OFF_IRQ_STAT: reg_rdata_o <= {6'h00, irq_stat};
			`NVMSA_OFF_IRQ_MASK: reg_rdata_o <= {6'h00, irq_mask};
			default:             reg_rdata_o <= 8'h00;
			endcase
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end
endmodule

// ---- testbench/nvmsa_monitor.sv ----
// assertion checker for the nvm self-access block
`timescale 1ns/1ps
module nvmsa_monitor #(
	parameter OP_CYCLES = 20
) (
	// clock, reset and register port
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic [3:0]  reg_addr_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_rdata_o,
	// storage side and core
	input wire logic [2:0]  mem_cmd_o,
	input wire logic [15:0] mem_addr_o,
	input wire logic        mem_flash_o,
	input wire logic        cpu_stall_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	logic [31:0] run;
	wire         timed = mem_cmd_o > 3'h2;
	// length of the running timed operation
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
			run <= 16'h0000;
		else
			run <= timed ? run + 32'h00000001 : 32'h00000000;
	sequence s_read;
		mem_cmd_o == 3'h1;
	endsequence
	property p_rdata_idle; !reg_rd_i |=> reg_rdata_o == 8'h00; endproperty
	property p_addr_hi; reg_rd_i && reg_addr_i == 4'h3 |=> reg_rdata_o[7]; endproperty
	property p_data_hi; reg_rd_i && reg_addr_i == 4'h1 |=> reg_rdata_o[7:6] == 2'b00; endproperty
	property p_read_once; s_read |=> mem_cmd_o == 3'h0; endproperty
	property p_cfg_read; s_read ##0 mem_addr_o[15] |-> mem_addr_o[14:0] inside {[0:3], [6:8]}; endproperty
	property p_cfg_write; mem_cmd_o > 3'h1 && mem_addr_o[15] |-> mem_addr_o[14:0] <= 15'h0003; endproperty
	property p_stall; cpu_stall_o == (mem_flash_o && (mem_cmd_o == 3'h3 || mem_cmd_o == 3'h4)); endproperty
	property p_latch_once; mem_cmd_o == 3'h2 |=> mem_cmd_o != 3'h2; endproperty
	property p_eeprom; mem_cmd_o == 3'h5 |-> !mem_flash_o; endproperty
	property p_op_len; $fell(timed) |-> run == OP_CYCLES; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
	a_addr_hi: assert property (p_addr_hi) else $error("address high bit 7 not one");
	a_data_hi: assert property (p_data_hi) else $error("data high top bits not zero");
	a_read_once: assert property (p_read_once) else $error("read command too long");
	a_cfg_read: assert property (p_cfg_read) else $error("read of bad config address");
	a_cfg_write: assert property (p_cfg_write) else $error("write to read-only config");
	a_stall: assert property (p_stall) else $error("stall mismatch");
	a_latch_once: assert property (p_latch_once) else $error("latch command too long");
	a_eeprom: assert property (p_eeprom) else $error("eeprom write on flash");
	a_op_len: assert property (p_op_len) else $error("timed op length wrong");
endmodule

bind nvmsa_top nvmsa_monitor #(.OP_CYCLES(OP_CYCLES)) u_mon (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mem_cmd_o(mem_cmd_o),
	.mem_addr_o(mem_addr_o), .mem_flash_o(mem_flash_o), .cpu_stall_o(cpu_stall_o));

// ---- testbench/nvmsa_top_test.sv ----
// self-checking bench for the nvm self-access block
`timescale 1ns/1ps
module nvmsa_top_test;
	localparam OPC = 20;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [3:0]  adr;
	logic [7:0]  wd;
	logic        wr;
	logic        rd;
	logic [7:0]  rdat;
	logic [2:0]  cmd;
	logic [15:0] madr;
	logic [13:0] mwd;
	logic        fl;
	logic        stall;
	logic        irq;
	logic [7:0]  v;
	logic [2:0]  last = 3'h0;
	wire  [13:0] md = madr[13:0] ^ 14'h2a5a;
	int          ncmd = 0, nst = 0, c0, s0, i, bad_count = 0, total_checks = 0;
	nvmsa_top #(.OP_CYCLES(OPC)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(adr), .reg_wdata_i(wd),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .mem_cmd_o(cmd), .mem_addr_o(madr),
		.mem_wdata_o(mwd), .mem_flash_o(fl), .mem_rdata_i(md), .cpu_stall_o(stall), .irq_o(irq));
	initial forever #4 clk_i = ~clk_i;
	// tally non-read storage commands and stalled cycles
	always @(posedge clk_i) if (cmd > 3'h1) begin
		last <= cmd;
		ncmd <= ncmd + 1;
		nst <= nst + stall;
	end
	task finish_test;
		if (bad_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input logic [15:0] s, e);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED %0t seen %h want %h", $time, s, e);
		end
	endtask
	task wrr(input logic [3:0] a, input logic [7:0] x);
		@(posedge clk_i);
		adr <= a;
		wd <= x;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	task rdr(input logic [3:0] a);
		@(posedge clk_i);
		adr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1 v = rdat;
	endtask
	task rc(input logic [3:0] a, input logic [7:0] e);
		rdr(a);
		chk(v, e);
	endtask
	// poll until both start bits have cleared
	task wait_idle;
		v = 8'h03;
		for (i = 0; i < 100 && v[1:0] !== 2'b00; i++)
			rdr(4'h4);
		if (i == 100) begin
			bad_count++;
			finish_test;
		end
		repeat (3) @(posedge clk_i);
	endtask
	// one write attempt: kind, command cycles, stalled cycles, control afterwards
	task op(input logic [7:0] c, input logic [2:0] k, input int n, ns, input logic [7:0] aft, input logic unl);
		if (unl) begin
			wrr(4'h5, 8'h55);
			wrr(4'h5, 8'haa);
		end
		c0 = ncmd;
		s0 = nst;
		wrr(4'h4, c);
		if (n > 1) begin
			rdr(4'h4);
			chk(v[1], 1'b1);
			wrr(4'h4, c & 8'hfd);
			rdr(4'h4);
			chk(v[1], 1'b1);
		end
		wait_idle;
		chk(v & 8'hf7, aft);
		chk(ncmd - c0, n);
		chk(nst - s0, ns);
		if (n > 0)
			chk(last, k);
	endtask
	initial begin
		adr = 4'h0;
		wd = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rc(4'h3, 8'h80);
		rc(4'h4, 8'h00);
		rc(4'h5, 8'h00);
		rc(4'hc, 8'h00);
		wrr(4'h1, 8'hff);
		rc(4'h1, 8'h3f);
		wrr(4'h3, 8'hff);
		rc(4'h3, 8'hff);
		wrr(4'h3, 8'h12);
		wrr(4'h2, 8'h34);
		wrr(4'h4, 8'h81);
		wait_idle;
		rc(4'h0, 8'h6e);
		rc(4'h1, 8'h38);
		chk(madr, 16'h1234);
		chk(fl, 1'b1);
		wrr(4'h4, 8'h01);
		wait_idle;
		chk(fl, 1'b0);
		wrr(4'h3, 8'h00);
		wrr(4'h2, 8'h06);
		wrr(4'h4, 8'h41);
		wait_idle;
		rc(4'h0, 8'h5c);
		rc(4'h1, 8'h2a);
		chk(madr, 16'h8006);
		wrr(4'h2, 8'h04);
		wrr(4'h4, 8'h41);
		wait_idle;
		rc(4'h0, 8'h00);
		rc(4'h1, 8'h00);
		op(8'h86, 3'h0, 0, 0, 8'h84, 1'b0);
		chk(v[3], 1'b1);
		chk(irq, 1'b0);
		rc(4'h6, 8'h02);
		wrr(4'h7, 8'h02);
		repeat (2) @(posedge clk_i);
		chk(irq, 1'b1);
		wrr(4'h6, 8'h02);
		repeat (2) @(posedge clk_i);
		chk(irq, 1'b0);
		wrr(4'h7, 8'h03);
		op(8'h82, 3'h0, 0, 0, 8'h80, 1'b1);
		wrr(4'h0, 8'ha5);
		wrr(4'h1, 8'h1c);
		wrr(4'h2, 8'h02);
		op(8'he6, 3'h2, 1, 0, 8'he4, 1'b1);
		chk(madr, 16'h8002);
		chk(mwd, 14'h1ca5);
		rc(4'h0, 8'ha5);
		rc(4'h1, 8'h1c);
		wrr(4'h2, 8'h06);
		op(8'hc6, 3'h0, 0, 0, 8'hc4, 1'b1);
		wrr(4'h2, 8'h10);
		op(8'h96, 3'h3, OPC, OPC, 8'h84, 1'b1);
		chk(v[3], 1'b0);
		op(8'h86, 3'h4, OPC, OPC, 8'h84, 1'b1);
		op(8'h36, 3'h5, OPC, 0, 8'h34, 1'b1);
		rc(4'h6, 8'h03);
		chk(irq, 1'b1);
		wrr(4'h6, 8'h03);
		repeat (2) @(posedge clk_i);
		chk(irq, 1'b0);
		finish_test;
	end
endmodule
